// File: fsc_pkg.sv
package fsc_pkg;
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 32;
    // register byte offsets
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_MAIN_INT  = 8'h04;
    localparam logic [7:0]  OFS_MAIN_NUM  = 8'h08;
    localparam logic [7:0]  OFS_MAIN_DEN  = 8'h0C;
    localparam logic [7:0]  OFS_MAIN_CFG  = 8'h10;
    localparam logic [7:0]  OFS_SYNC_CFG  = 8'h14;
    localparam logic [7:0]  OFS_SYNC_INT  = 8'h18;
    localparam logic [7:0]  OFS_SYNC_NUM  = 8'h1C;
    localparam logic [7:0]  OFS_SYNC_DEN  = 8'h20;
    localparam logic [7:0]  OFS_FRC_INTEG = 8'h24;
    localparam logic [7:0]  OFS_INTEG_RD  = 8'h28;
    localparam logic [7:0]  OFS_SPREAD    = 8'h2C;
    localparam logic [7:0]  OFS_CLK_SEL   = 8'h30;
    localparam logic [7:0]  OFS_STATUS    = 8'h34;
    // field positions
    localparam int unsigned BIT_LOOP_EN   = 0;
    localparam int unsigned BIT_FREE_RUN  = 1;
    localparam int unsigned BIT_SYNC_EN   = 2;
    localparam int unsigned BIT_STROBE    = 15;
    localparam int unsigned BIT_VALID     = 15;
    localparam int unsigned POS_GAIN      = 4;
    localparam int unsigned BIT_SYNC_BW   = 8;
    localparam int unsigned POS_SS_AMP    = 4;
    localparam int unsigned POS_SS_FREQ   = 8;
    localparam int unsigned BIT_SYS_SEL   = 0;
    localparam int unsigned BIT_DSP_SEL   = 1;
    // widths
    localparam int unsigned INT_W         = 10;
    localparam int unsigned FRAC_W        = 16;
    localparam int unsigned INTEG_W       = 12;
    // reset values
    localparam logic        RST_FREE_RUN  = 1'b1;
    localparam logic [9:0]  RST_MAIN_INT  = 10'h008;
    localparam logic [15:0] RST_MAIN_NUM  = 16'h0018;
    localparam logic [15:0] RST_MAIN_DEN  = 16'h007D;
    localparam logic [11:0] RST_FRC_INTEG = 12'h281;
    // synchronizer input ratio codes (divide by 1,2,4,8,16)
    localparam logic [2:0]  SYNC_CODE_MAX = 3'h4;
    localparam logic [4:0]  SYNC_DIV_ONE  = 5'h01;
    localparam logic [4:0]  SYNC_DIV_MAX  = 5'h10;
    typedef enum logic [1:0] {
        FSC_SS_OFF,
        FSC_SS_TRIANGLE,
        FSC_SS_ZERO_MEAN_FM,
        FSC_SS_DITHER
    } fsc_ss_mode_t;
    typedef enum logic [1:0] {
        FSC_LOOP_OFF,
        FSC_LOOP_LOCKED,
        FSC_LOOP_FREE
    } fsc_loop_state_t;
endpackage : fsc_pkg

// File: fsc_fll_ctrl.sv
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// - sync ratio codes divide by 1,2,4,8,16
// - multiplier fields are plain unsigned integers
// - with sync on, main denominator ignored
// - free-run needs loop enable too
// - free-run halts feedback, holds frequency
// - missing reference forces free-run, relock after
// - forced update loads integrator while free-run selected
// - cold free-run start applies default integrator
// - integrator readable, valid flag qualifies it
// - loop output selectable for system, core clocks
// - spread spectrum triangle, zero-mean or dither
// - main multiplier applied on update strobe
module fsc_fll_ctrl
    import fsc_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                ce,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [DATA_W-1:0]   pwdata,
    output logic      [DATA_W-1:0]   prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                ref_present_pin,
    input  wire logic                integ_stable_pin,
    input  wire logic [INTEG_W-1:0]  integ_value_pin,
    output logic                     loop_run,
    output logic                     feedback_halt,
    output logic                     sync_run,
    output logic      [INT_W-1:0]    act_int_mult,
    output logic      [FRAC_W-1:0]   act_frac_num,
    output logic      [FRAC_W-1:0]   act_frac_den,
    output logic                     frac_den_used,
    output logic      [4:0]          sync_div,
    output logic                     integ_load,
    output logic      [INTEG_W-1:0]  integ_load_value,
    output logic                     system_clock_from_loop,
    output logic                     processor_core_clock_from_loop,
    output fsc_ss_mode_t             ss_mode
);

    logic                 loop_enable;
    logic                 free_run_select;
    logic                 sync_path_enable;
    logic [INT_W-1:0]     main_integer_mult;
    logic [FRAC_W-1:0]    main_frac_numerator;
    logic [FRAC_W-1:0]    main_frac_denominator;
    logic [3:0]           main_vco_ratio;
    logic [3:0]           main_loop_gain;
    logic [2:0]           sync_input_ratio;
    logic [3:0]           sync_loop_gain;
    logic                 sync_bandwidth_select;
    logic [INT_W-1:0]     sync_integer_mult;
    logic [FRAC_W-1:0]    sync_frac_numerator;
    logic [FRAC_W-1:0]    sync_frac_denominator;
    logic [INTEG_W-1:0]   forced_integrator_value;
    logic [INTEG_W-1:0]   integrator_readback;
    logic                 integrator_readback_valid;
    logic [3:0]           ss_amp;
    logic [3:0]           ss_freq;
    logic                 has_run;
    logic                 loop_enable_q;
    fsc_loop_state_t      loop_state;
    fsc_loop_state_t      next_loop_state;
    logic [1:0]           ref_sync;
    logic [1:0]           stable_sync;
    logic [INTEG_W-1:0]   integ_meta;
    logic [INTEG_W-1:0]   integ_sync;
    logic                 access;
    logic                 wr_en;
    logic                 ratio_update_strobe;
    logic                 forced_integrator_update;
    logic                 mapped;
    logic [DATA_W-1:0]    rd_mux;
    logic                 ref_present;
    logic                 free_eff;

    assign ref_present = ref_sync[1];
    assign free_eff    = free_run_select | ~ref_present;
    assign access      = ce & psel & penable;
    assign wr_en       = access & pwrite & pready;
    assign ratio_update_strobe      = wr_en && paddr == OFS_MAIN_INT && pwdata[BIT_STROBE];
    assign forced_integrator_update = wr_en && paddr == OFS_FRC_INTEG && pwdata[BIT_STROBE];

    // pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_sync    <= '0;
            stable_sync <= '0;
            integ_meta  <= '0;
            integ_sync  <= '0;
        end else if (ce) begin
            ref_sync    <= {ref_sync[0], ref_present_pin};
            stable_sync <= {stable_sync[0], integ_stable_pin};
            integ_meta  <= integ_value_pin;
            integ_sync  <= integ_meta;
        end
    end

    always_comb begin
        unique case (paddr)
            OFS_CTRL, OFS_MAIN_INT, OFS_MAIN_NUM, OFS_MAIN_DEN, OFS_MAIN_CFG,
            OFS_SYNC_CFG, OFS_SYNC_INT, OFS_SYNC_NUM, OFS_SYNC_DEN, OFS_FRC_INTEG,
            OFS_INTEG_RD, OFS_SPREAD, OFS_CLK_SEL, OFS_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        rd_mux = '0;
        unique case (paddr)
            OFS_CTRL: begin
                rd_mux[BIT_LOOP_EN]  = loop_enable;
                rd_mux[BIT_FREE_RUN] = free_run_select;
                rd_mux[BIT_SYNC_EN]  = sync_path_enable;
            end
            OFS_MAIN_INT:  rd_mux[INT_W-1:0]   = main_integer_mult;
            OFS_MAIN_NUM:  rd_mux[FRAC_W-1:0]  = main_frac_numerator;
            OFS_MAIN_DEN:  rd_mux[FRAC_W-1:0]  = main_frac_denominator;
            OFS_MAIN_CFG:  rd_mux[7:0]         = {main_loop_gain, main_vco_ratio};
            OFS_SYNC_CFG: begin
                rd_mux[2:0]         = sync_input_ratio;
                rd_mux[7:4]         = sync_loop_gain;
                rd_mux[BIT_SYNC_BW] = sync_bandwidth_select;
            end
            OFS_SYNC_INT:  rd_mux[INT_W-1:0]   = sync_integer_mult;
            OFS_SYNC_NUM:  rd_mux[FRAC_W-1:0]  = sync_frac_numerator;
            OFS_SYNC_DEN:  rd_mux[FRAC_W-1:0]  = sync_frac_denominator;
            OFS_FRC_INTEG: rd_mux[INTEG_W-1:0] = forced_integrator_value;
            OFS_INTEG_RD: begin
                rd_mux[INTEG_W-1:0] = integrator_readback;
                rd_mux[BIT_VALID]   = integrator_readback_valid;
            end
            OFS_SPREAD:    rd_mux[11:0] = {ss_freq, ss_amp, 2'b00, ss_mode};
            OFS_CLK_SEL: begin
                rd_mux[BIT_SYS_SEL] = system_clock_from_loop;
                rd_mux[BIT_DSP_SEL] = processor_core_clock_from_loop;
            end
            OFS_STATUS:    rd_mux[3:0] = {has_run, feedback_halt, loop_run, ref_present};
            default:       rd_mux = '0;
        endcase
    end

    // apb answer, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (ce) begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel && penable && !pready && !pwrite)
                prdata <= rd_mux;
        end
    end

    // software-owned configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_enable           <= 1'b0;
            free_run_select       <= RST_FREE_RUN;
            sync_path_enable      <= 1'b0;
            main_integer_mult     <= RST_MAIN_INT;
            main_frac_numerator   <= RST_MAIN_NUM;
            main_frac_denominator <= RST_MAIN_DEN;
            main_vco_ratio        <= '0;
            main_loop_gain        <= '0;
            sync_input_ratio      <= '0;
            sync_loop_gain        <= '0;
            sync_bandwidth_select <= 1'b0;
            sync_integer_mult     <= '0;
            sync_frac_numerator   <= '0;
            sync_frac_denominator <= '0;
            forced_integrator_value <= RST_FRC_INTEG;
            ss_mode               <= FSC_SS_OFF;
            ss_amp                <= '0;
            ss_freq               <= '0;
            system_clock_from_loop         <= 1'b0;
            processor_core_clock_from_loop <= 1'b0;
        end else if (wr_en) begin
            unique case (paddr)
                OFS_CTRL: begin
                    loop_enable      <= pwdata[BIT_LOOP_EN];
                    free_run_select  <= pwdata[BIT_FREE_RUN];
                    sync_path_enable <= pwdata[BIT_SYNC_EN];
                end
                OFS_MAIN_INT: main_integer_mult     <= pwdata[INT_W-1:0];
                OFS_MAIN_NUM: main_frac_numerator   <= pwdata[FRAC_W-1:0];
                OFS_MAIN_DEN: main_frac_denominator <= pwdata[FRAC_W-1:0];
                OFS_MAIN_CFG: begin
                    main_vco_ratio <= pwdata[3:0];
                    main_loop_gain <= pwdata[POS_GAIN +: 4];
                end
                OFS_SYNC_CFG: begin
                    sync_input_ratio      <= pwdata[2:0];
                    sync_loop_gain        <= pwdata[POS_GAIN +: 4];
                    sync_bandwidth_select <= pwdata[BIT_SYNC_BW];
                end
                OFS_SYNC_INT:  sync_integer_mult       <= pwdata[INT_W-1:0];
                OFS_SYNC_NUM:  sync_frac_numerator     <= pwdata[FRAC_W-1:0];
                OFS_SYNC_DEN:  sync_frac_denominator   <= pwdata[FRAC_W-1:0];
                OFS_FRC_INTEG: forced_integrator_value <= pwdata[INTEG_W-1:0];
                OFS_SPREAD: begin
                    ss_mode <= fsc_ss_mode_t'(pwdata[1:0]);
                    ss_amp  <= pwdata[POS_SS_AMP +: 4];
                    ss_freq <= pwdata[POS_SS_FREQ +: 4];
                end
                OFS_CLK_SEL: begin
                    system_clock_from_loop         <= pwdata[BIT_SYS_SEL];
                    processor_core_clock_from_loop <= pwdata[BIT_DSP_SEL];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_int_mult <= RST_MAIN_INT;
            act_frac_num <= RST_MAIN_NUM;
        end else if (ce && ratio_update_strobe) begin
            act_int_mult <= pwdata[INT_W-1:0];
            act_frac_num <= main_frac_numerator;
        end else if (ce && !loop_enable) begin
            act_int_mult <= main_integer_mult;
            act_frac_num <= main_frac_numerator;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_frac_den  <= RST_MAIN_DEN;
            frac_den_used <= 1'b0;
        end else if (ce) begin
            frac_den_used <= ~sync_path_enable & (act_frac_num != '0);
            act_frac_den  <= sync_path_enable ? '0 : main_frac_denominator;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sync_div <= SYNC_DIV_ONE;
        else if (ce)
            sync_div <= (sync_input_ratio > SYNC_CODE_MAX) ? SYNC_DIV_MAX
                                                          : SYNC_DIV_ONE << sync_input_ratio;
    end

    always_comb begin
        next_loop_state = loop_state;
        unique case (loop_state)
            FSC_LOOP_OFF:
                if (loop_enable)
                    next_loop_state = free_eff ? FSC_LOOP_FREE : FSC_LOOP_LOCKED;
            FSC_LOOP_LOCKED:
                if (!loop_enable)
                    next_loop_state = FSC_LOOP_OFF;
                else if (free_eff)
                    next_loop_state = FSC_LOOP_FREE;
            FSC_LOOP_FREE:
                if (!loop_enable)
                    next_loop_state = FSC_LOOP_OFF;
                else if (!free_eff)
                    next_loop_state = FSC_LOOP_LOCKED;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_state    <= FSC_LOOP_OFF;
            loop_run      <= 1'b0;
            feedback_halt <= 1'b0;
            sync_run      <= 1'b0;
            loop_enable_q <= 1'b0;
            has_run       <= 1'b0;
        end else if (ce) begin
            loop_state    <= next_loop_state;
            loop_run      <= next_loop_state != FSC_LOOP_OFF;
            feedback_halt <= next_loop_state == FSC_LOOP_FREE;
            sync_run      <= next_loop_state == FSC_LOOP_LOCKED && sync_path_enable;
            loop_enable_q <= loop_enable;
            if (next_loop_state == FSC_LOOP_LOCKED)
                has_run <= 1'b1;
        end
    end

    // integrator load control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            integ_load       <= 1'b0;
            integ_load_value <= RST_FRC_INTEG;
        end else if (ce) begin
            integ_load <= 1'b0;
            if (loop_enable && !loop_enable_q && free_run_select && !has_run) begin
                integ_load       <= 1'b1;
                integ_load_value <= RST_FRC_INTEG;
            end else if (forced_integrator_update && free_run_select) begin
                integ_load       <= 1'b1;
                integ_load_value <= pwdata[INTEG_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            integrator_readback       <= '0;
            integrator_readback_valid <= 1'b0;
        end else if (ce) begin
            if (free_run_select && loop_state != FSC_LOOP_OFF && stable_sync[1]) begin
                integrator_readback       <= integ_sync;
                integrator_readback_valid <= 1'b1;
            end else if (!free_run_select) begin
                integrator_readback_valid <= 1'b0;
            end
        end
    end

    hold_mult_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && loop_enable && !ratio_update_strobe |=> $stable(act_int_mult))
        else $error("multiplier changed without update");

    apply_mult_a: assert property (@(posedge pclk) disable iff (!presetn)
        ratio_update_strobe |=> act_int_mult == $past(pwdata[INT_W-1:0]))
        else $error("strobe did not apply multiplier");

    ref_loss_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && loop_state == FSC_LOOP_LOCKED && !ref_present && loop_enable
        |=> feedback_halt)
        else $error("no halt on lost reference");

    relock_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && loop_state == FSC_LOOP_FREE && loop_enable && ref_present && !free_run_select
        |=> !feedback_halt && loop_run)
        else $error("no relock");

    need_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !loop_enable |=> !loop_run && !feedback_halt)
        else $error("loop running while disabled");

    force_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        forced_integrator_update && free_run_select && !(loop_enable && !loop_enable_q)
        |=> integ_load ##1 !integ_load)
        else $error("forced load not a single pulse");

    cold_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && loop_enable && !loop_enable_q && free_run_select && !has_run
        |=> integ_load && integ_load_value == RST_FRC_INTEG)
        else $error("default integrator not applied");

    valid_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !free_run_select |=> !integrator_readback_valid)
        else $error("valid flag stuck");

    sync_div_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && sync_input_ratio == 3'h3 |=> sync_div == 5'h08)
        else $error("sync ratio decode wrong");

    strobe_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready && !pwrite && paddr == OFS_MAIN_INT |-> !prdata[BIT_STROBE])
        else $error("strobe bit read back");

endmodule : fsc_fll_ctrl

// File: fsc_fll_ctrl_test.sv
`timescale 1ns/1ps
module fsc_fll_ctrl_test
    import fsc_pkg::*;
;
    logic                pclk = 1'b0;
    logic                presetn = 1'b0;
    logic                ce = 1'b1;
    logic                psel = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite = 1'b0;
    logic [ADDR_W-1:0]   paddr = '0;
    logic [DATA_W-1:0]   pwdata = '0;
    logic [DATA_W-1:0]   prdata;
    logic                pready;
    logic                pslverr;
    logic                ref_present_pin = 1'b0;
    logic                integ_stable_pin = 1'b0;
    logic [INTEG_W-1:0]  integ_value_pin = '0;
    logic                loop_run;
    logic                feedback_halt;
    logic                sync_run;
    logic [INT_W-1:0]    act_int_mult;
    logic [FRAC_W-1:0]   act_frac_num;
    logic [FRAC_W-1:0]   act_frac_den;
    logic                frac_den_used;
    logic [4:0]          sync_div;
    logic                integ_load;
    logic [INTEG_W-1:0]  integ_load_value;
    logic                sys_sel;
    logic                core_sel;
    fsc_ss_mode_t        ss_mode;
    int                  n_mismatch = 0;
    int                  tests_run = 0;
    logic [31:0]         rd;
    logic [31:0]         cfg;
    logic                err;
    logic                seen;

    always #2 pclk = ~pclk;

    fsc_fll_ctrl fsc_fll_ctrl_inst (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ref_present_pin(ref_present_pin),
        .integ_stable_pin(integ_stable_pin), .integ_value_pin(integ_value_pin),
        .loop_run(loop_run), .feedback_halt(feedback_halt), .sync_run(sync_run),
        .act_int_mult(act_int_mult), .act_frac_num(act_frac_num),
        .act_frac_den(act_frac_den), .frac_den_used(frac_den_used),
        .sync_div(sync_div), .integ_load(integ_load),
        .integ_load_value(integ_load_value), .system_clock_from_loop(sys_sel),
        .processor_core_clock_from_loop(core_sel), .ss_mode(ss_mode));

    task automatic report_and_stop;
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            chk("pready", 32'h0000_0001, 32'h0000_0000);
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic settle;
        repeat (8) @(posedge pclk);
    endtask : settle

    task automatic wait_load;
        seen = 1'b0;
        repeat (12) begin
            #1;
            if (integ_load === 1'b1 && !seen) begin
                seen = 1'b1;
                rd = {20'h0_0000, integ_load_value};
            end
            @(posedge pclk);
        end
    endtask : wait_load

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("int_rst", 32'h0000_0008, {22'h0, act_int_mult});
        chk("num_rst", 32'h0000_0018, {16'h0, act_frac_num});
        chk("den_rst", 32'h0000_007D, {16'h0, act_frac_den});
        chk("div_rst", 32'h0000_0001, {27'h0, sync_div});
        apb(1'b1, OFS_CTRL, 32'h0000_0003);
        wait_load();
        chk("cold_load", 32'h0000_1281, {19'h0, seen, rd[11:0]});
        settle();
        chk("free_state", 32'h0000_0003, {30'h0, loop_run, feedback_halt});
        integ_stable_pin <= 1'b1;
        integ_value_pin  <= 12'h3A5;
        settle();
        apb(1'b0, OFS_INTEG_RD, 32'h0000_0000);
        chk("integ_rd", 32'h0000_83A5, rd);
        apb(1'b1, OFS_FRC_INTEG, 32'h0000_8123);
        wait_load();
        chk("frc_load", 32'h0000_1123, {19'h0, seen, rd[11:0]});
        apb(1'b0, OFS_FRC_INTEG, 32'h0000_0000);
        chk("frc_rd", 32'h0000_0123, rd);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        settle();
        chk("noref_halt", 32'h0000_0003, {30'h0, loop_run, feedback_halt});
        apb(1'b0, OFS_INTEG_RD, 32'h0000_0000);
        chk("valid_clr", 32'h0000_0000, {16'h0, rd[15], 15'h0});
        apb(1'b1, OFS_FRC_INTEG, 32'h0000_8200);
        wait_load();
        chk("frc_ignored", 32'h0000_0000, {31'h0, seen});
        ref_present_pin <= 1'b1;
        settle();
        chk("relock", 32'h0000_0002, {30'h0, loop_run, feedback_halt});
        apb(1'b1, OFS_MAIN_INT, 32'h0000_0055);
        apb(1'b1, OFS_MAIN_DEN, 32'h0000_007D);
        apb(1'b1, OFS_MAIN_NUM, 32'h0000_0031);
        settle();
        chk("int_hold", 32'h0000_0008, {22'h0, act_int_mult});
        chk("num_hold", 32'h0000_0018, {16'h0, act_frac_num});
        apb(1'b1, OFS_MAIN_INT, 32'h0000_8066);
        settle();
        chk("int_upd", 32'h0066_0031, {6'h0, act_int_mult, act_frac_num});
        apb(1'b0, OFS_MAIN_INT, 32'h0000_0000);
        chk("upd_rd", 32'h0000_0066, rd);
        ce              <= 1'b0;
        ref_present_pin <= 1'b0;
        settle();
        chk("ce_freeze", 32'h0000_0002, {30'h0, loop_run, feedback_halt});
        ce <= 1'b1;
        settle();
        chk("ref_lost", 32'h0000_0003, {30'h0, loop_run, feedback_halt});
        ref_present_pin <= 1'b1;
        settle();
        chk("relock_again", 32'h0000_0002, {30'h0, loop_run, feedback_halt});
        apb(1'b1, OFS_CTRL, 32'h0000_0002);
        settle();
        chk("fr_no_en", 32'h0000_0000, {31'h0, loop_run});
        apb(1'b1, OFS_MAIN_INT, 32'h0000_0077);
        settle();
        chk("int_direct", 32'h0000_0077, {22'h0, act_int_mult});
        chk("den_used", 32'h0001_007D, {15'h0, frac_den_used, act_frac_den});
        apb(1'b1, OFS_CTRL, 32'h0000_0004);
        settle();
        chk("den_ign", 32'h0000_0000, {15'h0, frac_den_used, act_frac_den});
        apb(1'b1, OFS_CTRL, 32'h0000_0005);
        settle();
        chk("sync_run", 32'h0000_0001, {31'h0, sync_run});
        apb(1'b1, OFS_CTRL, 32'h0000_0004);
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        apb(1'b1, OFS_SYNC_INT, 32'h0000_00C0);
        apb(1'b0, OFS_SYNC_INT, 32'h0000_0000);
        chk("sync_int", 32'h0000_00C0, rd);
        apb(1'b1, OFS_SYNC_NUM, 32'h0000_0000);
        apb(1'b1, OFS_SYNC_DEN, 32'h0000_007D);
        apb(1'b0, OFS_SYNC_DEN, 32'h0000_0000);
        chk("sync_den", 32'h0000_007D, rd);
        apb(1'b1, OFS_SYNC_NUM, 32'h0000_0031);
        apb(1'b0, OFS_SYNC_NUM, 32'h0000_0000);
        chk("sync_num", 32'h0000_0031, rd);
        for (int c = 0; c < 5; c++) begin
            cfg = 32'(c);
            cfg[7:4] = (c == 0) ? 4'h4 : (c == 1) ? 4'h2 : 4'h0;
            cfg[BIT_SYNC_BW] = (c > 2);
            apb(1'b1, OFS_SYNC_CFG, cfg);
            settle();
            chk("sync_div", 32'h0000_0001 << c, {27'h0, sync_div});
            apb(1'b0, OFS_SYNC_CFG, 32'h0000_0000);
            chk("sync_cfg", cfg, rd);
        end
        for (int s = 1; s < 4; s++) begin
            apb(1'b1, OFS_CLK_SEL, 32'(s));
            settle();
            chk("clk_sel", 32'(s), {30'h0, core_sel, sys_sel});
        end
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, OFS_SPREAD, 32'(m));
            settle();
            chk("ss_mode", 32'(m), {30'h0, ss_mode});
        end
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, {rd[30:0], err});
        report_and_stop();
    end
endmodule : fsc_fll_ctrl_test
